// File: srs_group.sv
// one 16-bit status group: condition, transition filters, event latch, enable, summary
// assumes condition inputs come from logic on the same clock
`timescale 1ns/1ps
module srs_group
	import srs_pkg::*;
#(
	parameter int W = GRP_W
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] cond,
	input  wire logic         ptr_wr,
	input  wire logic         ntr_wr,
	input  wire logic         ena_wr,
	input  wire logic [W-1:0] wdata,
	input  wire logic         evt_clr,
	output logic      [W-1:0] cond_rt,
	output logic      [W-1:0] evt_q,
	output logic      [W-1:0] ptr_q,
	output logic      [W-1:0] ntr_q,
	output logic      [W-1:0] ena_q,
	output logic              summary
);
	logic [W-1:0] prev_q;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	logic [W-1:0] hit;
	logic [W-1:0] evt_d;
	logic [W-1:0] miss;

	////////////////////////////////////////////////////////////////////////////////
	// condition and edge detection
	assign cond_rt = cond & GRP_USED[W-1:0];
	assign rise = cond_rt & ~prev_q;
	assign fall = ~cond_rt & prev_q;
	assign hit = (rise & ptr_q) | (fall & ntr_q);
	assign miss = fall & ~ntr_q & ~evt_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_q <= '0;
		end else begin
			prev_q <= cond_rt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// event latch, set wins over clear
	always_comb begin
		evt_d = ((evt_clr ? '0 : evt_q) | hit) & GRP_USED[W-1:0];
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			evt_q <= '0;
		end else begin
			evt_q <= evt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// filters and enable, untouched by clear and queries
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_q <= PTR_RST[W-1:0];
			ntr_q <= NTR_RST[W-1:0];
			ena_q <= ENA_RST[W-1:0];
		end else begin
			if (ptr_wr) begin
				ptr_q <= wdata & GRP_USED[W-1:0];
			end
			if (ntr_wr) begin
				ntr_q <= wdata & GRP_USED[W-1:0];
			end
			if (ena_wr) begin
				ena_q <= wdata & GRP_USED[W-1:0];
			end
		end
	end

	assign summary = |(evt_q & ena_q);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	chk_evt_latch: assert property (@(posedge clk) disable iff (sys_rst) (|hit) |=> ((evt_q & $past(hit)) == $past(hit))) else $error("edge not latched");
	chk_evt_query_clr: assert property (@(posedge clk) disable iff (sys_rst) (evt_clr && hit == '0) |=> (evt_q == '0 && !summary)) else $error("event not cleared");
	chk_fall_ignored: assert property (@(posedge clk) disable iff (sys_rst) (miss != '0) |=> ((evt_q & $past(miss)) == '0)) else $error("falling edge latched");
	chk_msb_zero: assert property (@(posedge clk) disable iff (sys_rst) !evt_q[W-1] && !cond_rt[W-1] && !ena_q[W-1]) else $error("top bit set");
	chk_filter_keep: assert property (@(posedge clk) disable iff (sys_rst) (evt_clr && !ena_wr && !ptr_wr) |=> ($stable(ena_q) && $stable(ptr_q))) else $error("filter lost on clear");
	cov_both_edges: cover property (@(posedge clk) disable iff (sys_rst) (|(fall & ntr_q & ptr_q)) ##1 (evt_q != '0));
endmodule

// File: srs_host_model.sv
// host model: issues status commands and register queries over the command port
// assumes the core takes one command per rising edge and answers a read one cycle later
`timescale 1ns/1ps
module srs_host_model
	import srs_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             resp_valid_q,
	input  wire logic [GRP_W-1:0] resp_data_q,
	output logic                  cmd_valid,
	output logic      [3:0]       cmd_op,
	output logic      [1:0]       cmd_grp,
	output logic      [GRP_W-1:0] cmd_wdata
);
	initial begin
		cmd_valid = 1'b0;
		cmd_op = OP_NOP;
		cmd_grp = 2'h0;
		cmd_wdata = 16'h0000;
	end
	////////////////////////////////////////////////////////////////
	// one command; released fields never keep their last value
	task automatic send(input srs_op_t op, input logic [1:0] grp, input logic [GRP_W-1:0] wd);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_grp = grp;
		cmd_wdata = wd;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_op = OP_NOP;
		cmd_grp = ~grp;
		cmd_wdata = ~wd;
	endtask
	// status is known only by asking: select the register, query it, test the bits
	task automatic query(input srs_op_t op, input logic [1:0] grp, output logic [GRP_W-1:0] rd);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_grp = grp;
		cmd_wdata = 16'h5A5A;
		@(negedge clk);
		rd = (resp_valid_q === 1'b1) ? resp_data_q : 16'hXXXX;
		cmd_valid = 1'b0;
		cmd_op = OP_NOP;
		cmd_grp = ~grp;
		cmd_wdata = 16'hA5A5;
	endtask
endmodule

// File: srs_pkg.sv
// package for the status reporting block: widths, bit positions, reset values, command codes
// assumes a single system clock and a power-on reset that also marks the power-on event
package srs_pkg;
	localparam int GRP_W = 16;
	localparam int BYTE_W = 8;
	localparam int NUM_GRP = 3;
	localparam logic [GRP_W-1:0] GRP_USED = 16'h7FFF;
	localparam logic [GRP_W-1:0] PTR_RST = 16'h7FFF;
	localparam logic [GRP_W-1:0] NTR_RST = 16'h0000;
	localparam logic [GRP_W-1:0] ENA_RST = 16'h0000;
	localparam logic [BYTE_W-1:0] SRE_RST = 8'h00;
	localparam logic [BYTE_W-1:0] ESE_RST = 8'h00;
	localparam logic [BYTE_W-1:0] ESR_RST = 8'h80;
	// status byte bit positions
	localparam int STB_DEV = 1;
	localparam int STB_ERRQ = 2;
	localparam int STB_QUES = 3;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_RQS = 6;
	localparam int STB_OPER = 7;
	// standard event bit positions
	localparam int ESR_OPC = 0;
	localparam int ESR_QYE = 2;
	localparam int ESR_DDE = 3;
	localparam int ESR_EXE = 4;
	localparam int ESR_CME = 5;
	localparam int ESR_URQ = 6;
	localparam int ESR_PON = 7;
	localparam logic [BYTE_W-1:0] ESR_USED = 8'hFD;
	localparam logic [BYTE_W-1:0] STB_OTHERS = 8'hBE;

	typedef enum logic [3:0] {
		OP_NOP    = 4'h0,
		OP_COND_RD = 4'h1,
		OP_EVT_RD = 4'h2,
		OP_ENA_RD = 4'h3,
		OP_ENA_WR = 4'h4,
		OP_PTR_RD = 4'h5,
		OP_PTR_WR = 4'h6,
		OP_NTR_RD = 4'h7,
		OP_NTR_WR = 4'h8,
		OP_CLS    = 4'h9,
		OP_STB_RD = 4'hA,
		OP_SRE_WR = 4'hB,
		OP_SRE_RD = 4'hC,
		OP_ESR_RD = 4'hD,
		OP_ESE_WR = 4'hE,
		OP_ESE_RD = 4'hF
	} srs_op_t;

	typedef enum logic [1:0] {
		GRP_OPER = 2'h0,
		GRP_QUES = 2'h1,
		GRP_DEV  = 2'h2
	} srs_grp_t;
endpackage

// File: srs_status_core.sv
// status reporting core: three 16-bit groups, standard event byte, status byte and service request
// assumes a host command port on the same clock, one command per cycle, executed in arrival order
`timescale 1ns/1ps
// How it works
// - group summary is OR of event bits ANDed with enable bits
// - enable registers read-write, kept through clear-status and their own query
// - event query clears latched bits and the summary derived from them
// - with only rising filter, a falling condition edge latches nothing
// - with both filters every change latches; zero enable keeps summary zero
// - operation and questionable groups 16 bits; status byte and event byte 8
// - top bit of every 16-bit group is unused and reads zero
// - message-available bit 4 follows waiting output data, clears when all read
// - clearing an event register clears its status byte summary bit
// - status byte: 0 zero, 1 device, 2 error queue, 3 quest, 4 data, 5 event, 6 service, 7 oper
// - error-queue bit and data bit clear when their queues empty
// - service-request enable cleared only by power cycle or writing zero
// - status-byte query equals serial poll value and clears nothing
// - status-byte query is queued and runs after earlier commands
// - event byte: 0 done, 1 zero, 2 query, 3 device, 4 exec, 5 command, 6 user, 7 power
// - operation-complete set once overlapped work after the request has finished
// - power-on bit set after power restored since last read or clear
// - standard event byte cleared by clear-status and by its query
// - standard event enable cleared only by power cycle or writing zero
// - rising filter latches 0-to-1, falling filter 1-to-0; filters survive clears
// - event bits stay until cleared; repeated events are not buffered
// - condition registers are read-only and follow status in real time
module srs_status_core
	import srs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              cmd_valid,
	input  wire logic [3:0]        cmd_op,
	input  wire logic [1:0]        cmd_grp,
	input  wire logic [GRP_W-1:0]  cmd_wdata,
	input  wire logic [GRP_W-1:0]  oper_cond,
	input  wire logic [GRP_W-1:0]  ques_cond,
	input  wire logic [GRP_W-1:0]  dev_cond,
	input  wire logic              err_queue_nonempty,
	input  wire logic              out_queue_nonempty,
	input  wire logic              opc_req,
	input  wire logic              overlap_busy,
	input  wire logic              ev_query_err,
	input  wire logic              ev_device_err,
	input  wire logic              ev_exec_err,
	input  wire logic              ev_cmd_err,
	input  wire logic              ev_user_req,
	output logic                   resp_valid_q,
	output logic [GRP_W-1:0]       resp_data_q,
	output logic [BYTE_W-1:0]      status_byte_q,
	output logic                   srq_q
);
	srs_op_t                 op;
	logic [GRP_W-1:0]        cond_arr [NUM_GRP];
	logic [GRP_W-1:0]        cond_rt  [NUM_GRP];
	logic [GRP_W-1:0]        evt_arr  [NUM_GRP];
	logic [GRP_W-1:0]        ptr_arr  [NUM_GRP];
	logic [GRP_W-1:0]        ntr_arr  [NUM_GRP];
	logic [GRP_W-1:0]        ena_arr  [NUM_GRP];
	logic [NUM_GRP-1:0]      summ;
	logic [NUM_GRP-1:0]      ptr_wr;
	logic [NUM_GRP-1:0]      ntr_wr;
	logic [NUM_GRP-1:0]      ena_wr;
	logic [NUM_GRP-1:0]      evt_clr;
	logic                    do_cls;
	logic                    esr_clr;
	logic [BYTE_W-1:0]       esr_q;
	logic [BYTE_W-1:0]       esr_set;
	logic [BYTE_W-1:0]       esr_d;
	logic [BYTE_W-1:0]       ese_q;
	logic [BYTE_W-1:0]       sre_q;
	logic                    opc_armed_q;
	logic                    opc_done;
	logic [BYTE_W-1:0]       stb_d;
	logic                    is_read;
	logic [GRP_W-1:0]        rd_data;
	logic [1:0]              gi;

	assign op = srs_op_t'(cmd_op);
	assign gi = (cmd_grp > 2'h2) ? 2'h2 : cmd_grp;
	assign cond_arr[0] = oper_cond;
	assign cond_arr[1] = ques_cond;
	assign cond_arr[2] = dev_cond;

	////////////////////////////////////////////////////////////////////////////////
	// command decode, one per cycle in arrival order
	assign do_cls = cmd_valid && op == OP_CLS;
	assign esr_clr = do_cls || (cmd_valid && op == OP_ESR_RD);

	always_comb begin
		ptr_wr = '0;
		ntr_wr = '0;
		ena_wr = '0;
		evt_clr = {NUM_GRP{do_cls}};
		if (cmd_valid) begin
			case (op)
				OP_PTR_WR: ptr_wr[gi] = 1'b1;
				OP_NTR_WR: ntr_wr[gi] = 1'b1;
				OP_ENA_WR: ena_wr[gi] = 1'b1;
				OP_EVT_RD: evt_clr[gi] = 1'b1;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status groups
	generate
		for (genvar g = 0; g < NUM_GRP; g++) begin : grp
			srs_group #(.W(GRP_W)) u_grp (
				.clk     (clk),
				.sys_rst (sys_rst),
				.cond    (cond_arr[g]),
				.ptr_wr  (ptr_wr[g]),
				.ntr_wr  (ntr_wr[g]),
				.ena_wr  (ena_wr[g]),
				.wdata   (cmd_wdata),
				.evt_clr (evt_clr[g]),
				.cond_rt (cond_rt[g]),
				.evt_q   (evt_arr[g]),
				.ptr_q   (ptr_arr[g]),
				.ntr_q   (ntr_arr[g]),
				.ena_q   (ena_arr[g]),
				.summary (summ[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// operation complete tracking
	assign opc_done = opc_armed_q && !overlap_busy;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			opc_armed_q <= 1'b0;
		end else if (opc_req) begin
			opc_armed_q <= 1'b1;
		end else if (opc_done) begin
			opc_armed_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// standard event byte, set wins over clear, power-on bit preset by reset
	always_comb begin
		esr_set = '0;
		esr_set[ESR_OPC] = opc_done;
		esr_set[ESR_QYE] = ev_query_err;
		esr_set[ESR_DDE] = ev_device_err;
		esr_set[ESR_EXE] = ev_exec_err;
		esr_set[ESR_CME] = ev_cmd_err;
		esr_set[ESR_URQ] = ev_user_req;
		esr_d = ((esr_clr ? '0 : esr_q) | esr_set) & ESR_USED;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			esr_q <= ESR_RST;
		end else begin
			esr_q <= esr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// enable masks, only reset or a host write changes them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ese_q <= ESE_RST;
			sre_q <= SRE_RST;
		end else if (cmd_valid) begin
			if (op == OP_ESE_WR) begin
				ese_q <= cmd_wdata[BYTE_W-1:0];
			end
			if (op == OP_SRE_WR) begin
				sre_q <= cmd_wdata[BYTE_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status byte from current state, so a query sees all earlier commands
	always_comb begin
		stb_d = '0;
		stb_d[STB_DEV] = summ[GRP_DEV];
		stb_d[STB_ERRQ] = err_queue_nonempty;
		stb_d[STB_QUES] = summ[GRP_QUES];
		stb_d[STB_MAV] = out_queue_nonempty;
		stb_d[STB_ESB] = |(esr_q & ese_q);
		stb_d[STB_OPER] = summ[GRP_OPER];
		stb_d[STB_RQS] = |(stb_d & sre_q & STB_OTHERS);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_byte_q <= '0;
			srq_q <= 1'b0;
		end else begin
			status_byte_q <= stb_d;
			srq_q <= stb_d[STB_RQS];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// query answers
	always_comb begin
		is_read = 1'b1;
		rd_data = '0;
		case (op)
			OP_COND_RD: rd_data = cond_rt[gi];
			OP_EVT_RD: rd_data = evt_arr[gi];
			OP_ENA_RD: rd_data = ena_arr[gi];
			OP_PTR_RD: rd_data = ptr_arr[gi];
			OP_NTR_RD: rd_data = ntr_arr[gi];
			OP_STB_RD: rd_data = {8'h00, stb_d};
			OP_SRE_RD: rd_data = {8'h00, sre_q};
			OP_ESR_RD: rd_data = {8'h00, esr_q};
			OP_ESE_RD: rd_data = {8'h00, ese_q};
			default: is_read = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			resp_valid_q <= 1'b0;
			resp_data_q <= '0;
		end else begin
			resp_valid_q <= cmd_valid && is_read;
			if (cmd_valid && is_read) begin
				resp_data_q <= rd_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	chk_stb_layout: assert property (@(posedge clk) disable iff (sys_rst)
		!status_byte_q[0] && !esr_q[1])
		else $error("reserved bit set");
	chk_rqs_mask: assert property (@(posedge clk) disable iff (sys_rst)
		srq_q == |($past(sre_q) & status_byte_q & STB_OTHERS))
		else $error("service bit wrong");
	chk_mav_follow: assert property (@(posedge clk) disable iff (sys_rst)
		$past(sys_rst) || status_byte_q[STB_MAV] == $past(out_queue_nonempty))
		else $error("data bit wrong");
	chk_esr_query_clr: assert property (@(posedge clk) disable iff (sys_rst)
		esr_clr |=> esr_q == ($past(esr_set) & ESR_USED))
		else $error("event byte not cleared");
	chk_enable_keep: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && (op == OP_CLS || op == OP_STB_RD || op == OP_ESR_RD)) |=> $stable(ese_q) && $stable(sre_q))
		else $error("mask changed");
	chk_stb_read: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && op == OP_STB_RD) |=> resp_valid_q && resp_data_q[7:0] == status_byte_q)
		else $error("stb answer wrong");
	chk_opc_set: assert property (@(posedge clk) disable iff (sys_rst)
		(opc_armed_q && !overlap_busy) |=> esr_q[ESR_OPC] && (!opc_armed_q || $past(opc_req)))
		else $error("done bit missing");
	chk_esb_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(esr_clr && esr_set == '0) |=> ##1 !status_byte_q[STB_ESB])
		else $error("summary kept after clear");
	chk_errq_follow: assert property (@(posedge clk) disable iff (sys_rst)
		$past(sys_rst) || status_byte_q[STB_ERRQ] == $past(err_queue_nonempty))
		else $error("error queue bit wrong");
	chk_ques_summary: assert property (@(posedge clk) disable iff (sys_rst)
		$past(sys_rst) || status_byte_q[STB_QUES] == $past(|(evt_arr[GRP_QUES] & ena_arr[GRP_QUES])))
		else $error("summary bit wrong");
	chk_oper_sum_clr: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && op == OP_EVT_RD && gi == 2'h0 && $stable(oper_cond) && !$past(sys_rst)) |=> ##1 !status_byte_q[STB_OPER])
		else $error("summary kept after query");
	chk_ques_sum_clr: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && op == OP_EVT_RD && gi == 2'h1 && $stable(ques_cond) && !$past(sys_rst)) |=> ##1 !status_byte_q[STB_QUES])
		else $error("summary kept after query");
	chk_dev_sum_clr: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && op == OP_EVT_RD && gi == 2'h2 && $stable(dev_cond) && !$past(sys_rst)) |=> ##1 !status_byte_q[STB_DEV])
		else $error("summary kept after query");
	chk_sre_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(cmd_valid && op == OP_SRE_WR) |=> $stable(sre_q))
		else $error("service mask changed");
	chk_sre_write: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && op == OP_SRE_WR) |=> sre_q == $past(cmd_wdata[BYTE_W-1:0]))
		else $error("service mask not written");
	chk_ese_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(cmd_valid && op == OP_ESE_WR) |=> $stable(ese_q))
		else $error("event mask changed");
	chk_esr_answer: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && op == OP_ESR_RD) |=> resp_valid_q && resp_data_q == {8'h00, $past(esr_q)})
		else $error("event byte answer wrong");
	chk_stb_no_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && op == OP_STB_RD) |=> esr_q == (($past(esr_q) | $past(esr_set)) & ESR_USED))
		else $error("status query cleared events");
	chk_pon_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(esr_q[ESR_PON]) |-> !esr_q[ESR_PON])
		else $error("power bit set without reset");
	chk_opc_wait: assert property (@(posedge clk) disable iff (sys_rst)
		(!opc_done && !esr_q[ESR_OPC]) |=> !esr_q[ESR_OPC])
		else $error("done bit set early");
	chk_ask_only: assert property (@(posedge clk) disable iff (sys_rst)
		!cmd_valid |=> !resp_valid_q)
		else $error("answer without query");
	chk_top_zero: assert property (@(posedge clk) disable iff (sys_rst)
		!resp_data_q[GRP_W-1])
		else $error("answer top bit set");
	chk_byte_reads: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd_valid && op inside {OP_STB_RD, OP_SRE_RD, OP_ESR_RD, OP_ESE_RD}) |=> resp_data_q[GRP_W-1:BYTE_W] == '0)
		else $error("byte answer too wide");
	cov_stb_query: cover property (@(posedge clk) disable iff (sys_rst) cmd_valid && op == OP_STB_RD && stb_d[STB_RQS]);
	cov_opc_done: cover property (@(posedge clk) disable iff (sys_rst) opc_done);
	cov_cls: cover property (@(posedge clk) disable iff (sys_rst) do_cls && esr_q != '0);
	cov_evt_query: cover property (@(posedge clk) disable iff (sys_rst) cmd_valid && op == OP_EVT_RD && summ != '0);
endmodule

// File: srs_status_core_test.sv
// testbench for the status reporting core, host model on the command port
// assumes a 25 MHz clock and the core's one-cycle read answer
`timescale 1ns/1ps
module srs_status_core_test;
	import srs_pkg::*;
	logic             clk;
	logic             sys_rst;
	logic             cmd_valid;
	logic [3:0]       cmd_op;
	logic [1:0]       cmd_grp;
	logic [GRP_W-1:0] cmd_wdata;
	logic [GRP_W-1:0] oper_cond;
	logic [GRP_W-1:0] ques_cond;
	logic [GRP_W-1:0] dev_cond;
	logic             errq;
	logic             outq;
	logic             opc_req;
	logic             overlap_busy;
	logic [4:0]       ev;
	logic             resp_valid_q;
	logic [GRP_W-1:0] resp_data_q;
	logic [BYTE_W-1:0] status_byte_q;
	logic             srq_q;
	logic [GRP_W-1:0] rd;
	int               n_errors;
	int               check_count;
	always #20 clk = ~clk;
	srs_status_core uut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_grp(cmd_grp), .cmd_wdata(cmd_wdata), .oper_cond(oper_cond), .ques_cond(ques_cond),
		.dev_cond(dev_cond), .err_queue_nonempty(errq), .out_queue_nonempty(outq), .opc_req(opc_req),
		.overlap_busy(overlap_busy), .ev_query_err(ev[0]), .ev_device_err(ev[1]), .ev_exec_err(ev[2]),
		.ev_cmd_err(ev[3]), .ev_user_req(ev[4]), .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q),
		.status_byte_q(status_byte_q), .srq_q(srq_q));
	srs_host_model host (.clk(clk), .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_grp(cmd_grp), .cmd_wdata(cmd_wdata));
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [GRP_W-1:0] seen, input logic [GRP_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic [GRP_W-1:0] bv(input int n);
		return 16'h0001 << n;
	endfunction
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check("stb", {8'h00, status_byte_q}, 16'h0000);
		host.query(OP_ESR_RD, 2'h0, rd);
		check("pon", rd, bv(ESR_PON));
		host.query(OP_ESR_RD, 2'h0, rd);
		check("esr clr", rd, 16'h0000);
		host.query(OP_PTR_RD, 2'h0, rd);
		check("ptr", rd, PTR_RST);
		host.query(OP_NTR_RD, 2'h0, rd);
		check("ntr", rd, NTR_RST);
	endtask
	task automatic t_case_c;
		host.send(OP_ENA_WR, GRP_OPER, 16'h0001);
		oper_cond[0] = 1'b1;
		settle(3);
		check("oper sum", {8'h00, status_byte_q}, bv(STB_OPER));
		host.query(OP_EVT_RD, GRP_OPER, rd);
		check("oper evt", rd, 16'h0001);
		settle(2);
		check("oper clr", {8'h00, status_byte_q}, 16'h0000);
		oper_cond[0] = 1'b0;
		settle(3);
		check("fall sum", {8'h00, status_byte_q}, 16'h0000);
		host.query(OP_EVT_RD, GRP_OPER, rd);
		check("fall evt", rd, 16'h0000);
	endtask
	task automatic t_case_d;
		host.send(OP_PTR_WR, GRP_QUES, 16'h0001);
		host.send(OP_NTR_WR, GRP_QUES, 16'h0001);
		ques_cond[0] = 1'b1;
		settle(3);
		check("d sum", {8'h00, status_byte_q}, 16'h0000);
		host.query(OP_EVT_RD, GRP_QUES, rd);
		check("d rise", rd, 16'h0001);
		ques_cond[0] = 1'b0;
		settle(3);
		host.query(OP_EVT_RD, GRP_QUES, rd);
		check("d fall", rd, 16'h0001);
		ques_cond = 16'h8004;
		settle(1);
		host.query(OP_COND_RD, GRP_QUES, rd);
		check("cond", rd, 16'h0004);
		host.send(OP_ENA_WR, GRP_QUES, 16'hFFFF);
		host.query(OP_ENA_RD, GRP_QUES, rd);
		check("ena top", rd, GRP_USED);
		host.send(OP_CLS, 2'h0, 16'h0000);
		host.query(OP_ENA_RD, GRP_QUES, rd);
		check("ena cls", rd, GRP_USED);
		host.query(OP_PTR_RD, GRP_QUES, rd);
		check("ptr cls", rd, 16'h0001);
		host.send(OP_ENA_WR, GRP_QUES, 16'h0000);
		ques_cond = 16'h0000;
	endtask
	task automatic t_device;
		host.send(OP_ENA_WR, GRP_DEV, 16'h0002);
		dev_cond[1] = 1'b1;
		settle(3);
		check("dev sum", {8'h00, status_byte_q}, bv(STB_DEV));
		host.query(OP_EVT_RD, GRP_DEV, rd);
		check("dev evt", rd, 16'h0002);
		settle(2);
		check("dev clr", {8'h00, status_byte_q}, 16'h0000);
	endtask
	task automatic t_queues;
		errq = 1'b1;
		outq = 1'b1;
		settle(2);
		check("queues", {8'h00, status_byte_q}, bv(STB_ERRQ) | bv(STB_MAV));
		host.send(OP_SRE_WR, 2'h0, bv(STB_ERRQ));
		settle(3);
		check("srq", {15'h0000, srq_q}, 16'h0001);
		host.query(OP_STB_RD, 2'h0, rd);
		check("stb q", rd, bv(STB_ERRQ) | bv(STB_MAV) | bv(STB_RQS));
		host.query(OP_STB_RD, 2'h0, rd);
		check("stb q2", rd, bv(STB_ERRQ) | bv(STB_MAV) | bv(STB_RQS));
		host.send(OP_CLS, 2'h0, 16'h0000);
		host.query(OP_SRE_RD, 2'h0, rd);
		check("sre cls", rd, bv(STB_ERRQ));
		errq = 1'b0;
		settle(3);
		check("errq off", {8'h00, status_byte_q}, bv(STB_MAV));
		check("srq off", {15'h0000, srq_q}, 16'h0000);
		outq = 1'b0;
		settle(2);
		check("mav off", {8'h00, status_byte_q}, 16'h0000);
		host.send(OP_SRE_WR, 2'h0, 16'h0000);
		host.query(OP_SRE_RD, 2'h0, rd);
		check("sre 0", rd, 16'h0000);
	endtask
	task automatic t_std_event;
		host.send(OP_ESE_WR, 2'h0, {8'h00, ESR_USED});
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			ev = 5'h01 << i;
		end
		@(negedge clk);
		ev = 5'h00;
		opc_req = 1'b1;
		overlap_busy = 1'b1;
		@(negedge clk);
		opc_req = 1'b0;
		settle(3);
		check("esb", {8'h00, status_byte_q}, bv(STB_ESB));
		host.query(OP_ESR_RD, 2'h0, rd);
		check("esr bits", rd, 16'h007C);
		overlap_busy = 1'b0;
		settle(3);
		host.query(OP_ESR_RD, 2'h0, rd);
		check("opc", rd, bv(ESR_OPC));
		ev = 5'h08;
		@(negedge clk);
		ev = 5'h00;
		host.send(OP_CLS, 2'h0, 16'h0000);
		settle(2);
		check("esb cls", {8'h00, status_byte_q}, 16'h0000);
		host.query(OP_ESR_RD, 2'h0, rd);
		check("esr cls", rd, 16'h0000);
		host.query(OP_ESE_RD, 2'h0, rd);
		check("ese cls", rd, {8'h00, ESR_USED});
		host.send(OP_SRE_WR, 2'h0, bv(STB_ESB));
	endtask
	task automatic t_power_cycle;
		@(negedge clk);
		sys_rst = 1'b1;
		settle(2);
		sys_rst = 1'b0;
		host.query(OP_ESR_RD, 2'h0, rd);
		check("pon again", rd, bv(ESR_PON));
		host.query(OP_SRE_RD, 2'h0, rd);
		check("sre pwr", rd, 16'h0000);
		host.query(OP_ESE_RD, 2'h0, rd);
		check("ese pwr", rd, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#(5000 * 40);
		n_errors++;
		conclude();
	end
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		oper_cond = 16'h0000;
		ques_cond = 16'h0000;
		dev_cond = 16'h0000;
		errq = 1'b0;
		outq = 1'b0;
		opc_req = 1'b0;
		overlap_busy = 1'b0;
		ev = 5'h00;
		n_errors = 0;
		check_count = 0;
		settle(2);
		sys_rst = 1'b0;
		t_reset();
		t_case_c();
		t_case_d();
		t_device();
		t_queues();
		t_std_event();
		t_power_cycle();
		conclude();
	end
endmodule
